// ===== eep_pkg.sv
// Package for the on-chip nonvolatile array controller: APB map, field positions, resets.
// Assumes a 32-bit APB slave port with byte addresses and registers one word apart.
package eep_pkg;

  //////////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the APB
  localparam logic [15:0] OFS_MODULE_CONFIG = 16'h0000;
  localparam logic [15:0] OFS_BLOCK_PROTECT = 16'h0004;
  localparam logic [15:0] OFS_TEST_CONTROL = 16'h0008;
  localparam logic [15:0] OFS_PROGRAM_CONTROL = 16'h000C;
  localparam logic [15:0] OFS_ARRAY_MAP_INIT = 16'h0010;

  // Array windows: paddr[15:12] picks byte or word view, paddr[11:2] is the byte index
  localparam logic [3:0] WIN_BYTE = 4'h1;
  localparam logic [3:0] WIN_WORD = 4'h2;
  localparam logic [9:0] ARRAY_BYTES = 10'h300;
  localparam int unsigned ARRAY_WORDS = 384;
  localparam logic [8:0] LAST_WORD = 9'h17F;

  //////////////////////////////////////////////////////////////////////////////////////
  // Protection regions, lowest address first
  localparam logic [9:0] REGION3_START = 10'h100;
  localparam logic [9:0] REGION2_START = 10'h200;
  localparam logic [9:0] REGION1_START = 10'h280;
  localparam logic [9:0] REGION0_START = 10'h2C0;

  //////////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned CFG_SWAI = 2;
  localparam int unsigned CFG_LOCK = 1;
  localparam int unsigned CFG_RC = 0;
  localparam int unsigned PC_BULK = 7;
  localparam int unsigned PC_BYTE = 4;
  localparam int unsigned PC_ROW = 3;
  localparam int unsigned PC_ERASE = 2;
  localparam int unsigned PC_LATCH = 1;
  localparam int unsigned PC_PGM = 0;
  localparam int unsigned TST_ODD = 7;
  localparam int unsigned TST_EVEN = 6;
  localparam int unsigned TST_MARGIN_TEST = 5;
  localparam int unsigned TST_CPD = 4;
  localparam int unsigned TST_CPRD = 3;
  localparam int unsigned TST_CPM = 1;
  localparam int unsigned INIT_RD_EN = 0;
  localparam int unsigned INIT_LATCHED = 1;
  localparam int unsigned INIT_BUSY = 2;
  localparam int unsigned INIT_DONE = 3;

  //////////////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed bits
  localparam logic [7:0] CFG_RESET = 8'hFC;
  localparam logic [7:0] CFG_FIXED_ONES = 8'hF8;
  localparam logic [7:0] PROT_RESET = 8'hFF;
  localparam logic [7:0] PROT_FIXED_ONES = 8'hE0;
  localparam logic [7:0] PROG_RESET = 8'h80;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [7:0] TEST_WRITABLE = 8'hFA;
  localparam logic [7:0] INIT_RESET = 8'h01;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  typedef enum logic [1:0] {EEP_B_IDLE, EEP_B_RD1, EEP_B_RD2} eep_bus_e;

endpackage : eep_pkg

// ===== eep_mem.sv
// Word-wide storage for the nonvolatile array, two byte lanes, registered read data.
// Assumes the controller never reads and writes in the same cycle; content has no reset.
`timescale 1ns/100ps
module eep_mem (
  input wire logic pclk,
  input wire logic [1:0] we,
  input wire logic [8:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  logic [15:0] mem_q [0:eep_pkg::ARRAY_WORDS-1];

  // Lane 1 holds the even byte, lane 0 the odd byte
  always_ff @(posedge pclk) begin
    if (we[1]) begin
      mem_q[addr][15:8] <= wdata[15:8];
    end
    if (we[0]) begin
      mem_q[addr][7:0] <= wdata[7:0];
    end
    rdata <= mem_q[addr];
  end

endmodule : eep_mem

// ===== eep_ctrl.sv
// Program/erase controller for the 768-byte array with its APB register block.
// Assumes a synchronous APB master on pclk and mode inputs synchronous to pclk.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
module eep_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic normal_mode_flag,
  input wire logic wait_mode,
  input wire logic stop_mode,
  output logic pump_hv_on,
  output logic pump_rc_clk_en,
  output logic pump_ramp_en,
  output logic margin_test_out,
  output logic pump_monitor_out,
  output logic module_clk_stopped
);

  typedef struct packed {
    eep_pkg::eep_bus_e bst;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] rd_hi;
    logic swai;
    logic lock;
    logic lock_used;
    logic rc;
    logic [4:0] block_protect_bits;
    logic bulk;
    logic bsel;
    logic rsel;
    logic erase;
    logic lat;
    logic pgm;
    logic [7:0] test;
    logic rd_en;
    logic [9:0] lat_addr;
    logic [15:0] lat_data;
    logic lat_word;
    logic latched;
    logic [8:0] sw_addr;
    logic done;
    logic hv;
    logic rc_clk;
    logic ramp;
    logic margin_test;
    logic mon;
    logic clk_stop;
  } eep_ctrl_state_s;

  eep_ctrl_state_s s_q;
  eep_ctrl_state_s s_d;
  logic [1:0] mem_we;
  logic [8:0] mem_addr;
  logic [15:0] mem_wd;
  logic [15:0] mem_rd;
  logic acc;
  logic is_arr;
  logic is_word;
  logic mis;
  logic [9:0] idx;
  logic [7:0] tst;
  logic tmode;
  logic refused;

  //////////////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic prot_hit(input logic [9:0] b, input logic [4:0] bp);
    logic r;
    if (b < eep_pkg::REGION3_START) begin
      r = bp[4];
    end else if (b < eep_pkg::REGION2_START) begin
      r = bp[3];
    end else if (b < eep_pkg::REGION1_START) begin
      r = bp[2];
    end else if (b < eep_pkg::REGION0_START) begin
      r = bp[1];
    end else begin
      r = bp[0];
    end
    return r;
  endfunction : prot_hit

  assign acc = psel & penable & ~s_q.pready & (s_q.bst == eep_pkg::EEP_B_IDLE);
  assign idx = paddr[11:2];
  assign is_word = (paddr[15:12] == eep_pkg::WIN_WORD);
  assign is_arr = ((paddr[15:12] == eep_pkg::WIN_BYTE) | is_word) &
                  (idx < eep_pkg::ARRAY_BYTES) & (paddr[1:0] == 2'h0);
  assign mis = is_word & idx[0];
  // Test bits act only in special mode
  assign tst = normal_mode_flag ? 8'h00 : s_q.test;
  assign tmode = tst[eep_pkg::TST_ODD] | tst[eep_pkg::TST_EVEN];
  // Outside the odd/even row tests, a bulk or row erase under bulk protect, or a protected single target, gets no pump
  assign refused = (~tmode & s_q.erase & ~s_q.bsel & s_q.bulk) |
                   ((~tmode & (s_q.bsel | ~s_q.erase)) &
                    prot_hit(s_q.lat_addr, s_q.block_protect_bits));

  // Whether a byte belongs to the operation that is latched
  function automatic logic lane_sel(input logic [9:0] b, input eep_ctrl_state_s s,
                                    input logic [7:0] t);
    logic r;
    if (t[eep_pkg::TST_ODD] | t[eep_pkg::TST_EVEN]) begin
      // Row parity is bit 5 of the byte index, not the byte address parity
      r = (t[eep_pkg::TST_ODD] & b[5]) | (t[eep_pkg::TST_EVEN] & ~b[5]);
    end else if (s.erase & ~s.bsel) begin
      r = s.rsel ? (b[9:5] == s.lat_addr[9:5]) : 1'b1;
    end else if (s.lat_word) begin
      r = (b[9:1] == s.lat_addr[9:1]);
    end else begin
      r = (b == s.lat_addr);
    end
    return r;
  endfunction : lane_sel

  //////////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    mem_we = 2'b00;
    mem_addr = s_q.sw_addr;
    mem_wd = s_q.erase ? eep_pkg::ERASED_WORD : s_q.lat_data;
    if (normal_mode_flag) begin
      s_d.test = eep_pkg::TEST_RESET;
    end
    case (s_q.bst)
      eep_pkg::EEP_B_IDLE: begin
        if (acc & is_arr) begin
          if (pwrite) begin
            // Array writes only load the latches, and never during a pulse
            if (s_q.lat & ~s_q.pgm) begin
              s_d.lat_addr = idx;
              s_d.lat_word = is_word & ~idx[0];
              s_d.lat_data = is_word & ~idx[0] ? pwdata[15:0] :
                             (is_word ? {pwdata[15:8], pwdata[15:8]} :
                              {pwdata[7:0], pwdata[7:0]});
              s_d.latched = 1'b1;
              s_d.done = 1'b0;
              s_d.sw_addr = 9'h000;
            end
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
          end else if (~s_q.rd_en) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
          end else begin
            mem_addr = idx[9:1];
            s_d.bst = eep_pkg::EEP_B_RD1;
          end
        end else if (acc) begin
          s_d.pready = 1'b1;
          s_d.prdata = 32'h0000_0000;
          if (paddr == eep_pkg::OFS_MODULE_CONFIG) begin
            s_d.prdata[7:0] = eep_pkg::CFG_FIXED_ONES | {5'h00, s_q.swai, s_q.lock, s_q.rc};
            if (pwrite) begin
              s_d.swai = pwdata[eep_pkg::CFG_SWAI];
              s_d.rc = pwdata[eep_pkg::CFG_RC];
              if (~normal_mode_flag) begin
                s_d.lock = pwdata[eep_pkg::CFG_LOCK];
              end else if (~s_q.lock_used) begin
                s_d.lock = pwdata[eep_pkg::CFG_LOCK];
                s_d.lock_used = 1'b1;
              end
            end
          end else if (paddr == eep_pkg::OFS_BLOCK_PROTECT) begin
            s_d.prdata[7:0] = eep_pkg::PROT_FIXED_ONES | {3'h0, s_q.block_protect_bits};
            if (pwrite & ~s_q.pgm & ~s_q.lock) begin
              s_d.block_protect_bits = pwdata[4:0];
            end
          end else if (paddr == eep_pkg::OFS_TEST_CONTROL) begin
            s_d.prdata[7:0] = tst;
            if (pwrite & ~normal_mode_flag) begin
              s_d.test = pwdata[7:0] & eep_pkg::TEST_WRITABLE;
            end
          end else if (paddr == eep_pkg::OFS_PROGRAM_CONTROL) begin
            s_d.prdata[7:0] = {s_q.bulk, 2'b00, s_q.bsel, s_q.rsel, s_q.erase, s_q.lat, s_q.pgm};
            if (pwrite & s_q.pgm) begin
              // During a pulse only program enable may change
              s_d.pgm = pwdata[eep_pkg::PC_PGM];
            end else if (pwrite) begin
              if (~s_q.lock) begin
                s_d.bulk = pwdata[eep_pkg::PC_BULK];
              end
              s_d.bsel = pwdata[eep_pkg::PC_BYTE];
              s_d.rsel = pwdata[eep_pkg::PC_ROW];
              s_d.erase = pwdata[eep_pkg::PC_ERASE];
              s_d.lat = pwdata[eep_pkg::PC_LATCH];
              s_d.pgm = pwdata[eep_pkg::PC_PGM] & s_q.lat;
              if (~pwdata[eep_pkg::PC_LATCH]) begin
                s_d.latched = 1'b0;
              end
              s_d.done = 1'b0;
              s_d.sw_addr = 9'h000;
            end
          end else if (paddr == eep_pkg::OFS_ARRAY_MAP_INIT) begin
            s_d.prdata[7:0] = {4'h0, s_q.done, s_q.hv & ~s_q.done, s_q.latched, s_q.rd_en};
            if (pwrite) begin
              s_d.rd_en = pwdata[eep_pkg::INIT_RD_EN];
            end
          end else begin
            s_d.pslverr = 1'b1;
          end
        end else if (s_q.hv & s_q.latched & ~s_q.done) begin
          // Pump is on: sweep the array, one word a cycle, when the bus leaves it free
          for (int l = 0; l < 2; l++) begin
            mem_we[l] = lane_sel({s_q.sw_addr, ~l[0]}, s_q, tst) &
                        ~prot_hit({s_q.sw_addr, ~l[0]}, s_q.block_protect_bits);
          end
          s_d.sw_addr = s_q.sw_addr + 9'h001;
          if (s_q.sw_addr == eep_pkg::LAST_WORD) begin
            s_d.done = 1'b1;
          end
        end
      end
      eep_pkg::EEP_B_RD1: begin
        if (mis) begin
          // Second cycle fetches the next word; the last byte wraps to the first word
          s_d.rd_hi = mem_rd[7:0];
          mem_addr = idx[9:1] + 9'h001;
          if (idx[9:1] == eep_pkg::LAST_WORD) begin
            mem_addr = 9'h000;
          end
          s_d.bst = eep_pkg::EEP_B_RD2;
        end else begin
          s_d.prdata = is_word ? {16'h0000, mem_rd} :
                       {24'h00_0000, idx[0] ? mem_rd[7:0] : mem_rd[15:8]};
          s_d.pready = 1'b1;
          s_d.bst = eep_pkg::EEP_B_IDLE;
        end
      end
      eep_pkg::EEP_B_RD2: begin
        s_d.prdata = {16'h0000, s_q.rd_hi, mem_rd[15:8]};
        s_d.pready = 1'b1;
        s_d.bst = eep_pkg::EEP_B_IDLE;
      end
      default: begin
        s_d.bst = eep_pkg::EEP_B_IDLE;
      end
    endcase
    // Pump voltage follows program enable with latches loaded, except in stop, clocked-off wait, pump disable or refusal
    s_d.hv = s_q.pgm & s_q.latched & ~stop_mode & ~(wait_mode & s_q.swai) &
             ~tst[eep_pkg::TST_CPD] & ~refused;
    s_d.ramp = s_d.hv & ~tst[eep_pkg::TST_CPRD];
    s_d.rc_clk = s_q.rc & ~stop_mode & ~(wait_mode & s_q.swai);
    s_d.margin_test = tst[eep_pkg::TST_MARGIN_TEST];
    s_d.mon = tst[eep_pkg::TST_CPM];
    s_d.clk_stop = wait_mode & s_q.swai;
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.bst <= eep_pkg::EEP_B_IDLE;
      s_q.swai <= eep_pkg::CFG_RESET[eep_pkg::CFG_SWAI];
      s_q.lock <= eep_pkg::CFG_RESET[eep_pkg::CFG_LOCK];
      s_q.rc <= eep_pkg::CFG_RESET[eep_pkg::CFG_RC];
      s_q.block_protect_bits <= eep_pkg::PROT_RESET[4:0];
      s_q.bulk <= eep_pkg::PROG_RESET[eep_pkg::PC_BULK];
      s_q.test <= eep_pkg::TEST_RESET;
      s_q.rd_en <= eep_pkg::INIT_RESET[eep_pkg::INIT_RD_EN];
    end else begin
      s_q <= s_d;
    end
  end

  eep_mem u_mem (
    .pclk(pclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wd),
    .rdata(mem_rd)
  );

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign pump_hv_on = s_q.hv;
  assign pump_rc_clk_en = s_q.rc_clk;
  assign pump_ramp_en = s_q.ramp;
  assign margin_test_out = s_q.margin_test;
  assign pump_monitor_out = s_q.mon;
  assign module_clk_stopped = s_q.clk_stop;

  //////////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_aligned;
    acc && is_arr && !pwrite && s_q.rd_en && !mis;
  endsequence

  sequence s_rd_misaligned;
    acc && is_arr && !pwrite && s_q.rd_en && mis;
  endsequence

  AST_READ_ALIGNED: assert property (s_rd_aligned |=> !pready ##1 pready)
    else $error("aligned array read did not answer after one wait");
  AST_READ_MISALIGNED: assert property (s_rd_misaligned |=> !pready [*2] ##1 pready)
    else $error("misaligned array read did not answer after two waits");
  AST_PGM_NEEDS_LATCH: assert property ($rose(s_q.pgm) |-> $past(s_q.lat))
    else $error("program enable rose without latch enable set before");
  AST_STOP_DROPS_HV: assert property (stop_mode |=> !pump_hv_on && !pump_rc_clk_en)
    else $error("pump voltage or RC clock on during stop");
  AST_STOP_KEEPS_PGM: assert property (stop_mode && s_q.pgm && !(acc && pwrite)
                                       |=> s_q.pgm)
    else $error("program enable lost on entering stop");
  AST_PROT_FROZEN: assert property ((s_q.lock || s_q.pgm) |=> $stable(s_q.block_protect_bits))
    else $error("block protection changed while locked or programming");
  AST_TEST_ZERO_NORMAL: assert property (acc && !is_arr && !pwrite && normal_mode_flag &&
                                         paddr == eep_pkg::OFS_TEST_CONTROL
                                         |=> pready && prdata == 32'h0000_0000)
    else $error("test register read nonzero in normal mode");
  AST_PUMP_DISABLE: assert property (tst[eep_pkg::TST_CPD] |=> !pump_hv_on)
    else $error("pump on while disabled");
  AST_RC_STOPPED: assert property (!s_q.rc |=> !pump_rc_clk_en)
    else $error("RC oscillator running with system clock selected");
  AST_BULK_REFUSED: assert property (s_q.bulk && s_q.erase && !s_q.bsel && !tmode
                                     |=> !pump_hv_on)
    else $error("pump on for bulk or row erase under bulk protect");
  AST_NO_PROT_WRITE: assert property (mem_we[1] |->
                                      !prot_hit({mem_addr, 1'b0}, s_q.block_protect_bits))
    else $error("protected byte written");

endmodule : eep_ctrl

// ===== eep_apb_master.sv
// APB master model standing in for the CPU bus on the far side of the controller.
// Assumes one pclk domain; each transfer starts on the edge after the task is called.
`timescale 1ns/100ps
module eep_apb_master (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
  end
  ////////////////////////////////////////
  // Request is held until pready is seen at an edge; only the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output int n);
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not keep showing the old value
    pwdata <= ~d;
  endtask : xfer
endmodule : eep_apb_master

// ===== tb_top.sv
// Self-checking bench for the array controller: register map, program, erase, protection.
// Assumes the APB master model in its own file and the controller's package.
`timescale 1ns/100ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic normal_mode_flag = 1'b1;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic pump_hv_on, pump_rc_clk_en, pump_ramp_en, margin_test_out, pump_monitor_out;
  logic module_clk_stopped, erv;
  int n_errors = 0;
  int checked = 0;
  int lat, lat0, cyc = 0;
  logic ramp_off = 1'b0;
  localparam logic [15:0] A_CFG = eep_pkg::OFS_MODULE_CONFIG;
  localparam logic [15:0] A_PROT = eep_pkg::OFS_BLOCK_PROTECT;
  localparam logic [15:0] A_TST = eep_pkg::OFS_TEST_CONTROL;
  localparam logic [15:0] A_PC = eep_pkg::OFS_PROGRAM_CONTROL;
  localparam logic [15:0] A_INIT = eep_pkg::OFS_ARRAY_MAP_INIT;

  always #4 pclk = ~pclk;

  eep_ctrl eep_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .normal_mode_flag(normal_mode_flag), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .pump_hv_on(pump_hv_on), .pump_rc_clk_en(pump_rc_clk_en),
    .pump_ramp_en(pump_ramp_en), .margin_test_out(margin_test_out),
    .pump_monitor_out(pump_monitor_out), .module_clk_stopped(module_clk_stopped));

  eep_apb_master eep_apb_master_inst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // Whole run is near 3600 cycles; the ceiling leaves ample slack
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("MISMATCH timeout expected 0 seen %0d", cyc);
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    eep_apb_master_inst.xfer(1'b1, a, d, rdv, erv, lat);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    eep_apb_master_inst.xfer(1'b0, a, 32'h00000000, rdv, erv, lat);
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask : settle

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  function automatic logic [15:0] ba(input logic [9:0] i);
    return {eep_pkg::WIN_BYTE, i, 2'b00};
  endfunction : ba

  function automatic logic [15:0] wa(input logic [9:0] i);
    return {eep_pkg::WIN_WORD, i, 2'b00};
  endfunction : wa

  // Latch, address, enable, sweep, then the two closing writes
  task automatic pe_op(input logic [7:0] m, input logic [15:0] a, input logic [31:0] d,
                       input logic hv, input logic mid);
    int k;
    wr(A_PC, {24'h000000, m | 8'h02});
    wr(a, d);
    wr(A_PC, {24'h000000, m | 8'h03});
    settle();
    chk("pump_hv_on", {31'h0, hv}, {31'h0, pump_hv_on});
    chk("pump_ramp_en", {31'h0, hv & ~ramp_off}, {31'h0, pump_ramp_en});
    if (mid) begin
      chk("pump_rc_clk_en", 32'h1, {31'h0, pump_rc_clk_en});
      chk("pump_ramp_en", 32'h1, {31'h0, pump_ramp_en});
      wr(A_PROT, 32'h000000FF);
      rd(A_PROT);
      chk("protect in pgm", 32'h000000E0, rdv);
      @(posedge pclk);
      stop_mode <= 1'b1;
      settle();
      chk("hv in stop", 32'h0, {31'h0, pump_hv_on});
      chk("rc in stop", 32'h0, {31'h0, pump_rc_clk_en});
      stop_mode <= 1'b0;
      settle();
      chk("hv after stop", 32'h1, {31'h0, pump_hv_on});
      rd(A_PC);
      chk("pgm kept", {24'h000000, m | 8'h03}, rdv);
    end
    if (hv) begin
      k = 0;
      do begin
        rd(A_INIT);
        k++;
      end while (rdv[eep_pkg::INIT_DONE] !== 1'b1 && k < 300);
      chk("done", 32'h1, {31'h0, rdv[eep_pkg::INIT_DONE]});
    end
    wr(A_PC, {24'h000000, m | 8'h02});
    wr(A_PC, 32'h00000000);
  endtask : pe_op

  ////////////////////////////////////////
  initial begin
    do_reset();
    rd(A_CFG);
    chk("cfg reset", {24'h0, eep_pkg::CFG_RESET}, rdv);
    rd(A_PROT);
    chk("prot reset", {24'h0, eep_pkg::PROT_RESET}, rdv);
    rd(A_TST);
    chk("test reset", 32'h00000000, rdv);
    rd(A_PC);
    chk("pc reset", {24'h0, eep_pkg::PROG_RESET}, rdv);
    rd(A_INIT);
    chk("init reset", {24'h0, eep_pkg::INIT_RESET}, rdv);
    rd(16'h0014);
    chk("unmapped err", 32'h1, {31'h0, erv});
    $display("test reset_map done");
    wr(A_TST, 32'h000000FF);
    rd(A_TST);
    chk("test normal", 32'h00000000, rdv);
    normal_mode_flag <= 1'b0;
    wr(A_TST, 32'h000000FF);
    rd(A_TST);
    chk("test special", {24'h0, eep_pkg::TEST_WRITABLE}, rdv);
    chk("margin out", 32'h1, {31'h0, margin_test_out});
    chk("monitor out", 32'h1, {31'h0, pump_monitor_out});
    wr(A_TST, 32'h00000000);
    normal_mode_flag <= 1'b1;
    wr(A_PC, 32'h00000003);
    rd(A_PC);
    chk("latch only", 32'h00000002, rdv);
    wr(A_PC, 32'h00000000);
    @(posedge pclk);
    wait_mode <= 1'b1;
    settle();
    chk("clk stopped", 32'h1, {31'h0, module_clk_stopped});
    wait_mode <= 1'b0;
    $display("test registers done");
    wr(A_PROT, 32'h00000000);
    rd(A_PROT);
    chk("prot write", 32'h000000E0, rdv);
    wr(A_CFG, 32'h00000001);
    rd(A_CFG);
    chk("cfg rc", 32'h000000F9, rdv);
    @(posedge pclk);
    wait_mode <= 1'b1;
    settle();
    chk("clk running", 32'h0, {31'h0, module_clk_stopped});
    wait_mode <= 1'b0;
    pe_op(8'h04, ba(10'h000), 32'h0, 1'b1, 1'b1);
    rd(ba(10'h010));
    chk("erased byte", 32'h000000FF, rdv);
    rd(wa(10'h2FE));
    chk("erased word", 32'h0000FFFF, rdv);
    pe_op(8'h00, ba(10'h010), 32'h000000A5, 1'b1, 1'b0);
    pe_op(8'h00, wa(10'h011), 32'h00001234, 1'b1, 1'b0);
    rd(wa(10'h010));
    lat0 = lat;
    chk("aligned word", 32'h0000A512, rdv);
    rd(wa(10'h011));
    chk("misaligned word", 32'h000012FF, rdv);
    chk("misaligned lat", lat0 + 1, lat);
    rd(ba(10'h012));
    chk("upper untouched", 32'h000000FF, rdv);
    $display("test program done");
    pe_op(8'h14, ba(10'h010), 32'h0, 1'b1, 1'b0);
    rd(ba(10'h010));
    chk("byte erase", 32'h000000FF, rdv);
    rd(ba(10'h011));
    chk("byte erase scope", 32'h00000012, rdv);
    pe_op(8'h0C, ba(10'h000), 32'h0, 1'b1, 1'b0);
    rd(ba(10'h011));
    chk("row erase", 32'h000000FF, rdv);
    pe_op(8'h8C, ba(10'h000), 32'h0, 1'b0, 1'b0);
    wr(A_PROT, 32'h00000010);
    pe_op(8'h00, ba(10'h020), 32'h0000005A, 1'b0, 1'b0);
    rd(ba(10'h020));
    chk("protected byte", 32'h000000FF, rdv);
    wr(A_INIT, 32'h00000000);
    rd(ba(10'h012));
    chk("read disabled", 32'h00000000, rdv);
    rd(A_PROT);
    chk("regs while off", 32'h000000F0, rdv);
    wr(A_INIT, 32'h00000001);
    $display("test erase_protect done");
    do_reset();
    wr(A_CFG, 32'h00000002);
    wr(A_CFG, 32'h00000004);
    rd(A_CFG);
    chk("lock once", 32'h000000FE, rdv);
    wr(A_PROT, 32'h00000000);
    rd(A_PROT);
    chk("prot locked", 32'h000000FF, rdv);
    normal_mode_flag <= 1'b0;
    wr(A_CFG, 32'h00000000);
    rd(A_CFG);
    chk("lock special", 32'h000000F8, rdv);
    $display("test lock done");
    wr(A_PROT, 32'h00000000);
    wr(A_TST, 32'h00000088);
    ramp_off = 1'b1;
    pe_op(8'h00, ba(10'h020), 32'h0000005A, 1'b1, 1'b0);
    rd(ba(10'h021));
    chk("odd row", 32'h0000005A, rdv);
    rd(ba(10'h010));
    chk("even row kept", 32'h000000FF, rdv);
    wr(A_TST, 32'h00000010);
    pe_op(8'h00, ba(10'h040), 32'h00000033, 1'b0, 1'b0);
    rd(ba(10'h040));
    chk("pump disabled", 32'h000000FF, rdv);
    $display("test test_mode done");
    end_sim();
  end
endmodule : tb_top
